// [rtl/swc_dev.sv]
`timescale 1ns/100ps
`include "swc_defs.svh"
module swc_dev (
  input  wire logic        pclk,
  input  wire logic        presetn,
  swc_link_if.dev          link,
  output logic [3:0][8:0]  wiper_pos_r,
  output logic [1:0][8:0]  term_ctrl_r,
  output logic             hv_active_r
);

  logic [1:0]          cs_sync_r;
  logic [1:0]          hv_sync_r;
  logic [1:0]          sck_sync_r;
  logic [1:0]          sdi_sync_r;
  logic                sck_prev_r;
  logic                act_prev_r;
  logic                act;
  logic                act_start;
  logic                sck_rise;
  logic                sck_fall;
  logic [4:0]          cnt_r;
  logic [4:0]          cnt_nxt;
  logic [15:0]         shift_r;
  logic [15:0]         shift_nxt;
  logic [3:0]          addr_r;
  swc_pkg::swc_op_t    op_r;
  logic                err_r;
  logic                nv_pend_r;
  logic                step_done;
  logic                write_done;
  logic                sdo_r;
  logic                sdo_oe_r;

  // Wiper index for addresses 0, 1, 6 and 7.
  function automatic logic [1:0] wiper_idx(input logic [3:0] a);
    wiper_idx = {a[2], a[0]};
  endfunction

  function automatic logic is_wiper(input logic [3:0] a);
    is_wiper = (a == `SWC_ADDR_WIPER0) || (a == `SWC_ADDR_WIPER1) ||
               (a == `SWC_ADDR_WIPER2) || (a == `SWC_ADDR_WIPER3);
  endfunction

  function automatic logic is_term(input logic [3:0] a);
    is_term = (a == `SWC_ADDR_TERM0) || (a == `SWC_ADDR_TERM1);
  endfunction

  function automatic logic is_nv(input logic [3:0] a);
    logic [15:0] mask;
    mask = `SWC_NV_ADDR_MASK;
    is_nv = mask[a];
  endfunction

  // Supported address/opcode pairs; stepping is only legal on wipers.
  function automatic logic cmd_ok(input logic [3:0] a, input swc_pkg::swc_op_t op);
    if (op == swc_pkg::SWC_OP_INC || op == swc_pkg::SWC_OP_DEC) begin
      cmd_ok = is_wiper(a);
    end else begin
      cmd_ok = is_wiper(a) || is_term(a) || is_nv(a);
    end
  endfunction

  // Saturating step; values above full scale freeze the wiper.
  function automatic swc_pkg::swc_word9_t step(input swc_pkg::swc_word9_t w, input logic up);
    if (up) begin
      step = (w < `SWC_WIPER_FULL) ? 9'(w + 9'h001) : w;
    end else begin
      step = (w != 9'h000 && w <= `SWC_WIPER_FULL) ? 9'(w - 9'h001) : w;
    end
  endfunction

  function automatic swc_pkg::swc_word9_t read_loc(input logic [3:0] a);
    if (is_wiper(a)) begin
      read_loc = wiper_pos_r[wiper_idx(a)];
    end else if (is_term(a)) begin
      read_loc = term_ctrl_r[a[3]];
    end else begin
      read_loc = 9'h000;
    end
  endfunction

  // Value of the serial output for bit position n of the current command.
  function automatic logic sdo_bit(input logic [4:0] n);
    swc_pkg::swc_word9_t d;
    d = read_loc(addr_r);
    if (n < `SWC_CNT_FLAG) begin
      sdo_bit = 1'b1;
    end else if (n == `SWC_CNT_FLAG) begin
      sdo_bit = 1'b1;
    end else if (op_r == swc_pkg::SWC_OP_READ && n < `SWC_CNT_LONG) begin
      sdo_bit = d[4'(5'd15 - n)];
    end else begin
      sdo_bit = 1'b1;
    end
  endfunction

  // Every link pin passes two flip-flops before any logic looks at it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_sync_r  <= 2'h3;
      hv_sync_r  <= 2'h0;
      sck_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], link.cs_n};
      hv_sync_r  <= {hv_sync_r[0], link.hv_sel};
      sck_sync_r <= {sck_sync_r[0], link.sck};
      sdi_sync_r <= {sdi_sync_r[0], link.sdi};
    end
  end

  // Edge history of the synchronised clock and select.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_r <= 1'b0;
      act_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= sck_sync_r[1];
      act_prev_r <= act;
    end
  end

  // Select counts as active at the normal low level or the high-voltage level.
  assign act       = !cs_sync_r[1] || hv_sync_r[1];
  assign act_start = act && !act_prev_r;
  assign sck_rise  = act && !act_start && sck_sync_r[1] && !sck_prev_r;
  assign sck_fall  = act && !act_start && !sck_sync_r[1] && sck_prev_r;
  assign cnt_nxt   = 5'(cnt_r + 5'h01);
  assign shift_nxt = {shift_r[14:0], sdi_sync_r[1]};

  // Completion of a command; nothing short of its full count executes.
  assign step_done  = sck_rise && !err_r && cnt_nxt == `SWC_CNT_SHORT &&
                      (op_r == swc_pkg::SWC_OP_INC || op_r == swc_pkg::SWC_OP_DEC);
  assign write_done = sck_rise && !err_r && cnt_nxt == `SWC_CNT_LONG &&
                      op_r == swc_pkg::SWC_OP_WRITE;

  // Bit counter, shifter and command decode. A release of select in the
  // middle of a command simply drops the partial bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 5'h00;
      shift_r   <= 16'h0000;
      addr_r    <= 4'h0;
      op_r      <= swc_pkg::SWC_OP_WRITE;
      err_r     <= 1'b0;
      nv_pend_r <= 1'b0;
    end else if (!act || act_start) begin
      cnt_r     <= 5'h00;
      err_r     <= 1'b0;
      nv_pend_r <= 1'b0;
    end else if (sck_rise && !err_r) begin
      shift_r <= shift_nxt;
      if (cnt_nxt == `SWC_CNT_DECODE) begin
        addr_r <= shift_nxt[5:2];
        op_r   <= swc_pkg::swc_op_t'(shift_nxt[1:0]);
        cnt_r  <= cnt_nxt;
        if (!cmd_ok(shift_nxt[5:2], swc_pkg::swc_op_t'(shift_nxt[1:0])) || nv_pend_r) begin
          err_r <= 1'b1;
        end
      end else if (step_done || cnt_nxt == `SWC_CNT_LONG) begin
        cnt_r <= 5'h00;
        if (write_done && is_nv(addr_r)) begin
          nv_pend_r <= 1'b1;
        end
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Wiper registers: written after sixteen bits, stepped after eight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_pos_r <= {4{`SWC_WIPER_RST}};
    end else if (write_done && is_wiper(addr_r)) begin
      wiper_pos_r[wiper_idx(addr_r)] <= shift_nxt[8:0];
    end else if (step_done) begin
      wiper_pos_r[wiper_idx(addr_r)] <=
        step(wiper_pos_r[wiper_idx(addr_r)], op_r == swc_pkg::SWC_OP_INC);
    end
  end

  // Terminal control registers take writes only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_ctrl_r <= {2{`SWC_TERM_RST}};
    end else if (write_done && is_term(addr_r)) begin
      term_ctrl_r[addr_r[3]] <= shift_nxt[8:0];
    end
  end

  // Serial output changes only on falling clock edges, so the host sees it
  // stable at its sampling edge; after an error it stays low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_r    <= 1'b1;
      sdo_oe_r <= 1'b0;
    end else if (!act) begin
      sdo_r    <= 1'b1;
      sdo_oe_r <= 1'b0;
    end else if (act_start) begin
      sdo_r    <= 1'b1;
      sdo_oe_r <= 1'b1;
    end else if (sck_fall) begin
      sdo_r <= err_r ? 1'b0 : sdo_bit(cnt_r);
    end
  end

  // Records whether the current select period opened at the high-voltage level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_active_r <= 1'b0;
    end else if (act_start) begin
      hv_active_r <= hv_sync_r[1];
    end else if (!act) begin
      hv_active_r <= 1'b0;
    end
  end

  assign link.sdo    = sdo_r;
  assign link.sdo_oe = sdo_oe_r;

endmodule

// [rtl/swc_defs.svh]
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
// Notes on behaviour
// - Flag high for supported address/opcode pairs.
// - Further command after nonvolatile write is invalid.
// - Clock counts not multiple of eight ignored.
// - After error ignore commands, output low.
// - Execute only after full clock count.
// - Inactive select resets interface until reactivation.
// - Valid commands may follow back to back.
// - Host keeps one command kind per select.
// - Host splits long chains into short ones.
// - Host holds select inactive when idle.
// - Write updates location after sixteen bits.
// - No write unless exactly sixteen clocks.
// - Chained writes only to volatile addresses.
// - Read: flag on seventh bit, nine bits.
// - Chained reads allowed to every location.
// - Increment is eight bits, adds one.
// - Increment/decrement elsewhere than wipers invalid.
// - Opcodes: 11 read, 00 write, 01/10 step.
// - Serial output high for first six bits.
// - Data word is msb bit plus byte.

// Memory locations.
`define SWC_ADDR_WIPER0    4'h0
`define SWC_ADDR_WIPER1    4'h1
`define SWC_ADDR_TERM0     4'h4
`define SWC_ADDR_WIPER2    4'h6
`define SWC_ADDR_WIPER3    4'h7
`define SWC_ADDR_TERM1     4'ha
// One bit per address that holds nonvolatile memory; this variant has none.
`define SWC_NV_ADDR_MASK   16'h0000

// Reset and limit values of the locations.
`define SWC_WIPER_RST      9'h080
`define SWC_TERM_RST       9'h1ff
`define SWC_WIPER_FULL     9'h100

// Bit counts inside one command.
`define SWC_CNT_DECODE     5'h06
`define SWC_CNT_FLAG       5'h06
`define SWC_CNT_MSB        5'h07
`define SWC_CNT_SHORT      5'h08
`define SWC_CNT_LONG       5'h10

// Serial clock made by the host.
`define SWC_PCLK_PERIOD_NS 25
`define SWC_SCK_PERIOD_NS  400
`define SWC_SCK_HALF_CYC   (`SWC_SCK_PERIOD_NS / 2 / `SWC_PCLK_PERIOD_NS)

// Host register offsets and fields.
`define SWC_REG_CMD        12'h000
`define SWC_REG_CFG        12'h004
`define SWC_REG_STAT       12'h008
`define SWC_CMD_LONG       16
`define SWC_CMD_HOLD       17
`define SWC_CMD_HV         18
`define SWC_CMD_RELEASE    19
`define SWC_CFG_CPOL       0
`define SWC_STAT_BUSY      0
`define SWC_STAT_HELD      1
`define SWC_STAT_CPOL      2
`endif

// [rtl/swc_pkg.sv]
package swc_pkg;
  // Opcode field encodings.
  typedef enum logic [1:0] {
    SWC_OP_WRITE = 2'b00,
    SWC_OP_INC   = 2'b01,
    SWC_OP_DEC   = 2'b10,
    SWC_OP_READ  = 2'b11
  } swc_op_t;

  typedef logic [8:0] swc_word9_t;

  // Host sequencer states.
  typedef enum logic [2:0] {
    SWC_H_IDLE,
    SWC_H_SETUP,
    SWC_H_LOW,
    SWC_H_HIGH,
    SWC_H_GAP
  } swc_hstate_t;
endpackage

// [rtl/swc_link_if.sv]
`timescale 1ns/100ps
// Serial link between host and device; the device releases its output
// when deselected, and the line then reads high as through a pull-up.
interface swc_link_if;
  logic cs_n;
  logic hv_sel;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev  (input cs_n, input hv_sel, input sck, input sdi, output sdo, output sdo_oe);
  modport host (output cs_n, output hv_sel, output sck, output sdi, input sdo_line);
endinterface

// [rtl/swc_host.sv]
`timescale 1ns/100ps
`include "swc_defs.svh"
module swc_host (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  swc_link_if.host          link
);

  swc_pkg::swc_hstate_t state_r;
  logic [1:0]           sdo_sync_r;
  logic                 cs_n_r;
  logic                 hv_r;
  logic                 sck_r;
  logic                 sdi_r;
  logic [15:0]          tx_r;
  logic [15:0]          rx_r;
  logic [4:0]           bits_r;
  logic [7:0]           tmr_r;
  logic                 hold_r;
  logic                 cpol_r;
  logic                 apb_req;
  logic                 apb_wr;
  logic                 cmd_wr;
  logic                 tmr_end;

  // Registers answer in the second access cycle, so the bus sees one wait.
  assign apb_req = psel && penable && !pready;
  assign apb_wr  = psel && penable && pready && pwrite;
  assign cmd_wr  = apb_wr && paddr == `SWC_REG_CMD && state_r == swc_pkg::SWC_H_IDLE;
  assign tmr_end = tmr_r == 8'(`SWC_SCK_HALF_CYC - 1);

  // Bus answer with read data; unmapped offsets give an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apb_req;
      pslverr <= apb_req && paddr != `SWC_REG_CMD && paddr != `SWC_REG_CFG &&
                 paddr != `SWC_REG_STAT;
      prdata  <= 32'h00000000;
      if (apb_req && !pwrite && paddr == `SWC_REG_STAT) begin
        prdata[`SWC_STAT_BUSY] <= state_r != swc_pkg::SWC_H_IDLE;
        prdata[`SWC_STAT_HELD] <= !cs_n_r;
        prdata[`SWC_STAT_CPOL] <= cpol_r;
        prdata[31:16]          <= rx_r;
      end else if (apb_req && !pwrite && paddr == `SWC_REG_CFG) begin
        prdata[`SWC_CFG_CPOL] <= cpol_r;
      end
    end
  end

  // Clock polarity may only change while the link is idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpol_r <= 1'b0;
    end else if (apb_wr && paddr == `SWC_REG_CFG && state_r == swc_pkg::SWC_H_IDLE && cs_n_r) begin
      cpol_r <= pwdata[`SWC_CFG_CPOL];
    end
  end

  // Device output arrives from another timing domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_sync_r <= 2'h3;
    end else begin
      sdo_sync_r <= {sdo_sync_r[0], link.sdo_line};
    end
  end

  // Link sequencer: select, then per bit a low half and a high half of the
  // divided clock; data moves with the fall and is sampled at the rise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= swc_pkg::SWC_H_IDLE;
      cs_n_r  <= 1'b1;
      hv_r    <= 1'b0;
      sck_r   <= 1'b0;
      sdi_r   <= 1'b0;
      tx_r    <= 16'h0000;
      rx_r    <= 16'h0000;
      bits_r  <= 5'h00;
      tmr_r   <= 8'h00;
      hold_r  <= 1'b0;
    end else begin
      tmr_r <= tmr_end ? 8'h00 : 8'(tmr_r + 8'h01);
      case (state_r)
        swc_pkg::SWC_H_IDLE: begin
          tmr_r <= 8'h00;
          if (cs_n_r) begin
            sck_r <= cpol_r;
          end
          if (cmd_wr && pwdata[`SWC_CMD_RELEASE]) begin
            cs_n_r  <= 1'b1;
            hv_r    <= 1'b0;
            state_r <= swc_pkg::SWC_H_GAP;
          end else if (cmd_wr) begin
            tx_r    <= pwdata[15:0];
            rx_r    <= 16'h0000;
            bits_r  <= pwdata[`SWC_CMD_LONG] ? `SWC_CNT_LONG : `SWC_CNT_SHORT;
            hold_r  <= pwdata[`SWC_CMD_HOLD];
            cs_n_r  <= 1'b0;
            hv_r    <= pwdata[`SWC_CMD_HV];
            sdi_r   <= pwdata[15];
            state_r <= cs_n_r ? swc_pkg::SWC_H_SETUP : swc_pkg::SWC_H_LOW;
            if (!cs_n_r) begin
              sck_r <= 1'b0;
            end
          end
        end
        swc_pkg::SWC_H_SETUP: begin
          if (tmr_end) begin
            sck_r   <= 1'b0;
            state_r <= swc_pkg::SWC_H_LOW;
          end
        end
        swc_pkg::SWC_H_LOW: begin
          if (tmr_end) begin
            sck_r   <= 1'b1;
            rx_r    <= {rx_r[14:0], sdo_sync_r[1]};
            state_r <= swc_pkg::SWC_H_HIGH;
          end
        end
        swc_pkg::SWC_H_HIGH: begin
          if (tmr_end) begin
            tx_r   <= {tx_r[14:0], 1'b0};
            sdi_r  <= tx_r[14];
            bits_r <= 5'(bits_r - 5'h01);
            if (bits_r != 5'h01) begin
              sck_r   <= 1'b0;
              state_r <= swc_pkg::SWC_H_LOW;
            end else if (hold_r) begin
              sck_r   <= cpol_r;
              state_r <= swc_pkg::SWC_H_IDLE;
            end else begin
              sck_r   <= cpol_r;
              cs_n_r  <= 1'b1;
              hv_r    <= 1'b0;
              state_r <= swc_pkg::SWC_H_GAP;
            end
          end
        end
        swc_pkg::SWC_H_GAP: begin
          if (tmr_end) begin
            state_r <= swc_pkg::SWC_H_IDLE;
          end
        end
        default: begin
          state_r <= swc_pkg::SWC_H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n   = cs_n_r;
  assign link.hv_sel = hv_r;
  assign link.sck    = sck_r;
  assign link.sdi    = sdi_r;

endmodule

// [sim/swc_link_properties.sv]
`timescale 1ns/100ps
// Watches the serial link from the wire side, apart from both ends.
module swc_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic hv_sel,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  logic       sck_r;
  logic [4:0] idx_r;
  logic [5:0] cmd_r;
  logic       err_r;
  logic [2:0] rise_r;
  logic       act;
  logic       rise;
  logic       step;

  // A select at either level opens a frame; only rising clock edges inside it count.
  assign act  = !cs_n || hv_sel;
  assign rise = sck && !sck_r && act;
  assign step = cmd_r[1:0] == 2'b01 || cmd_r[1:0] == 2'b10;

  // Own decode of the address/opcode pair, so a wrong table in the device shows up.
  function automatic logic pair_ok(input logic [5:0] c);
    logic st;
    st = c[5:2] inside {4'h0, 4'h1, 4'h6, 4'h7};
    return (c[1:0] == 2'b01 || c[1:0] == 2'b10) ? st : st || c[5:2] inside {4'h4, 4'ha};
  endfunction

  // Bit position, command head and error state of the frame seen on the wire.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_r  <= 1'b0;
      idx_r  <= 5'h00;
      cmd_r  <= 6'h00;
      err_r  <= 1'b0;
      rise_r <= 3'h0;
    end else begin
      sck_r <= sck;
      if (!act) begin
        idx_r  <= 5'h00;
        err_r  <= 1'b0;
        rise_r <= 3'h0;
      end else if (rise) begin
        rise_r <= rise_r + 3'h1;
        idx_r  <= (idx_r == (step ? 5'h07 : 5'h0f)) ? 5'h00 : idx_r + 5'h01;
        if (idx_r < 5'h06) begin
          cmd_r <= {cmd_r[4:0], sdi};
        end
        if (idx_r == 5'h06 && !pair_ok(cmd_r)) begin
          err_r <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_open;
    $rose(act);
  endsequence
  sequence s_close;
    $fell(act);
  endsequence

  AST_CMD_FLAG: assert property (
    rise && idx_r == 5'h06 |-> sdo_line == (pair_ok(cmd_r) && !err_r))
    else $error("validity bit on the wire is wrong");
  AST_ERR_LOW: assert property (
    rise && err_r |-> !sdo_line)
    else $error("output not low after a bad command");
  AST_HEAD_HIGH: assert property (
    rise && !err_r && (idx_r < 5'h06 || (idx_r > 5'h06 && cmd_r[1:0] != 2'b11)) |-> sdo_line)
    else $error("output not high outside flag and read data");
  AST_SDO_EDGE: assert property (
    sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck)
    else $error("device output moved while the clock was high");
  AST_SDI_HOLD: assert property (
    rise |-> $stable(sdi) ##1 $stable(sdi)[*4])
    else $error("host data moved around a sampling edge");
  AST_WHOLE_BYTES: assert property (
    s_close |-> rise_r == 3'h0)
    else $error("frame did not hold whole bytes");
  AST_RELEASE_OE: assert property (
    s_close |-> ##[1:6] !sdo_oe)
    else $error("device kept driving after deselect");
  AST_START_DRIVE: assert property (
    s_open |-> ##[1:6] (sdo_oe && sdo_line))
    else $error("device did not drive high after select");
endmodule

// [sim/spi_wiper_command_decoder_bench.sv]
`timescale 1ns/100ps
`include "swc_defs.svh"
// Drives the host over APB and checks the device at its outputs and over the link.
module spi_wiper_command_decoder_bench;
  typedef struct {
    logic [31:0] val;
    logic [31:0] mask;
  } swc_note_t;

  logic            pclk;
  logic            presetn;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [3:0][8:0] wpos;
  logic [1:0][8:0] term;
  logic            hv_act;
  logic [8:0]      mem [16];
  logic [3:0]      rw [6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'ha};
  logic [3:0]      sa [6] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h6, 4'h7};
  logic            su [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic            watch;
  logic            cpol;
  logic [31:0]     seed;
  int              bad_count;
  int              checks_done;
  swc_note_t       notes [$];
  swc_note_t       note;

  swc_link_if link_inst ();
  swc_host swc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_inst.host));
  swc_dev swc_dev_inst (.pclk(pclk), .presetn(presetn), .link(link_inst.dev),
    .wiper_pos_r(wpos), .term_ctrl_r(term), .hv_active_r(hv_act));
  swc_link_properties swc_link_properties_inst (.pclk(pclk), .presetn(presetn),
    .cs_n(link_inst.cs_n), .hv_sel(link_inst.hv_sel), .sck(link_inst.sck),
    .sdi(link_inst.sdi), .sdo(link_inst.sdo), .sdo_oe(link_inst.sdo_oe),
    .sdo_line(link_inst.sdo_line));

  // Free-running 40 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Xorshift keeps the data varied but repeatable from one run to the next.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One APB transfer; the trailing idle edge keeps psel from being set twice in a step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic idle(input logic [31:0] cmd);
    logic [31:0] q;
    logic        e;
    apb(1'b1, `SWC_REG_CMD, cmd, q, e);
    do begin
      apb(1'b0, `SWC_REG_STAT, 32'h0, q, e);
    end while (q[0] !== 1'b0);
  endtask

  // Sends one command, then notes the expected status and reads it.
  task automatic frame(input logic [15:0] w, input logic lng, input logic hld,
                       input logic hv, input logic [15:0] rx);
    logic [31:0] q;
    logic        e;
    idle({12'h000, 1'b0, hv, hld, lng, w});
    notes.push_back('{{rx, 13'h0000, cpol, hld, 1'b0}, lng ? 32'hffff_0007 : 32'h00ff_0007});
    watch = 1'b1;
    apb(1'b0, `SWC_REG_STAT, 32'h0, q, e);
    watch = 1'b0;
  endtask

  task automatic do_wr(input logic [3:0] a, input logic [8:0] d, input logic hld,
                       input logic hv);
    frame({a, 2'b00, 1'b0, d}, 1'b1, hld, hv, 16'hffff);
    mem[a] = d;
  endtask

  task automatic do_rd(input logic [3:0] a, input logic hld);
    frame({a, 2'b11, 10'h000}, 1'b1, hld, 1'b0, {7'h7f, mem[a]});
  endtask

  // Steps saturate at full scale and values above it stay frozen.
  task automatic do_step(input logic [3:0] a, input logic up, input logic hld);
    frame({a, up ? 2'b01 : 2'b10, 10'h000}, 1'b0, hld, 1'b0, 16'h00ff);
    if (up && mem[a] < `SWC_WIPER_FULL) begin
      mem[a] = mem[a] + 9'h001;
    end
    if (!up && mem[a] <= `SWC_WIPER_FULL && mem[a] != 9'h000) begin
      mem[a] = mem[a] - 9'h001;
    end
  endtask

  task automatic ports();
    for (int i = 0; i < 4; i++) begin
      chk("wiper", {23'h0, wpos[i]}, {23'h0, mem[i < 2 ? i : i + 4]});
    end
    chk("term0", {23'h0, term[0]}, {23'h0, mem[4]});
    chk("term1", {23'h0, term[1]}, {23'h0, mem[10]});
  endtask

  // Compares each watched status read with the oldest note.
  always @(posedge pclk) begin
    if (watch && psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      chk("status", prdata & note.mask, note.val);
    end
  end

  // Cuts a hang short; the longest run is far below this span.
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    logic [31:0] q;
    logic        e;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, watch, cpol, bad_count, checks_done} = '0;
    seed = 32'h0000_113f;
    for (int i = 0; i < 16; i++) begin
      mem[i] = `SWC_WIPER_RST;
    end
    mem[4]  = `SWC_TERM_RST;
    mem[10] = `SWC_TERM_RST;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    ports();
    for (int i = 0; i < 6; i++) begin
      do_wr(rw[i], 9'(rnd()), i < 5, 1'b0);
    end
    ports();
    for (int i = 0; i < 6; i++) begin
      do_rd(rw[i], i < 5);
    end
    do_wr(4'h0, 9'h0ff, 1'b1, 1'b0);
    do_wr(4'h1, 9'h001, 1'b1, 1'b0);
    do_wr(4'h6, 9'h150, 1'b1, 1'b0);
    do_wr(4'h7, 9'h100, 1'b0, 1'b0);
    // Steps of one kind share a select period; a change of kind reopens it.
    for (int i = 0; i < 6; i++) begin
      do_step(sa[i], su[i], i < 5 && su[i] == su[(i + 1) % 6]);
    end
    idle(32'h0008_0000);
    ports();
    // A bad pair blocks the rest of the select period.
    frame({4'h4, 2'b01, 10'h000}, 1'b0, 1'b1, 1'b0, 16'h00fc);
    frame({4'h1, 2'b01, 10'h000}, 1'b0, 1'b1, 1'b0, 16'h0000);
    idle(32'h0008_0000);
    frame({4'h2, 2'b11, 10'h000}, 1'b1, 1'b0, 1'b0, 16'hfc00);
    frame({4'h0, 2'b00, 10'h000}, 1'b0, 1'b0, 1'b0, 16'h00ff);
    ports();
    do_wr(4'h1, 9'(rnd()), 1'b1, 1'b1);
    chk("hv_active", {31'h0, hv_act}, 32'h1);
    idle(32'h0008_0000);
    chk("hv_active", {31'h0, hv_act}, 32'h0);
    apb(1'b1, `SWC_REG_CFG, 32'h1, q, e);
    cpol = 1'b1;
    do_rd(4'h1, 1'b1);
    do_rd(4'h6, 1'b0);
    do_step(4'h1, 1'b0, 1'b0);
    ports();
    apb(1'b0, 12'h00c, 32'h0, q, e);
    chk("unmapped", {31'h0, e}, 32'h1);
    report_and_stop();
  end
endmodule
